// ---- csfu_host_model.sv ----
`timescale 1ns/10ps
module csfu_host_model (
  input  wire logic                 clk,
  input  wire logic                 rvalid_q,
  input  wire logic [7:0]           rdata_q,
  output csfu_pkg::csfu_access_type access
);
  import csfu_pkg::*;
  initial access = '0;
  // One strobe per request, answer taken one cycle later
  task automatic xfer(input logic wr, input logic [7:0] op, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk) #1;
    access = '{~wr, wr, op, d};
    @(posedge clk) #1;
    // Released lines show the inverse, not the last value
    access = '{1'b0, 1'b0, ~op, ~d};
    q = (wr || rvalid_q === 1'b1) ? rdata_q : 8'hxx;
  endtask : xfer
endmodule : csfu_host_model

// ---- csfu_pkg.sv ----
package csfu_pkg;

  // Register access opcodes
  localparam logic [7:0] CSFU_OP_FLAGS_READ  = 8'hE2;
  localparam logic [7:0] CSFU_OP_ENABLE_WRITE = 8'h1E;
  localparam logic [7:0] CSFU_OP_ENABLE_READ = 8'hE6;

  // Flag bit positions
  localparam int CSFU_BIT_TX_EMPTY    = 7;
  localparam int CSFU_BIT_TX_FULL     = 6;
  localparam int CSFU_BIT_TX_HISTORY  = 5;
  localparam int CSFU_BIT_ERR_WARNING = 4;
  localparam int CSFU_BIT_ERR_PASSIVE = 3;
  localparam int CSFU_BIT_BUS_OFF     = 2;
  localparam int CSFU_BIT_RX_EMPTY    = 1;
  localparam int CSFU_BIT_RX_FULL     = 0;

  // Reset values
  localparam logic [7:0] CSFU_FLAGS_RESET  = 8'h82;
  localparam logic [7:0] CSFU_ENABLE_RESET = 8'h82;
  localparam logic [7:0] CSFU_GP_SEL_RESET = 8'h00;

  // FIFO depths and error count window
  localparam logic [3:0] CSFU_TX_DEPTH      = 4'h8;
  localparam logic [3:0] CSFU_RX_DEPTH      = 4'h8;
  localparam logic [3:0] CSFU_HISTORY_DEPTH = 4'h8;
  localparam logic [7:0] CSFU_WARN_LOW      = 8'h60;
  localparam logic [7:0] CSFU_WARN_HIGH     = 8'h7F;

  // Selector codes that reach the status flags
  localparam logic [3:0] CSFU_GP_STATUS_BASE = 4'h8;

  typedef enum logic [1:0] {
    CSFU_FC_ACTIVE  = 2'b00,
    CSFU_FC_PASSIVE = 2'b01,
    CSFU_FC_BUS_OFF = 2'b10
  } csfu_fc_state_type;

  typedef struct packed {
    logic [3:0]        tx_count;
    logic [3:0]        rx_count;
    logic [3:0]        history_count;
    logic [7:0]        tx_error_count;
    logic [7:0]        rx_error_count;
    csfu_fc_state_type fc_state;
  } csfu_engine_type;

  typedef struct packed {
    logic       read_strobe;
    logic       write_strobe;
    logic [7:0] opcode;
    logic [7:0] wdata;
  } csfu_access_type;

  typedef struct packed {
    logic [7:0] interrupt_flags;
    logic [7:0] gp_pin_select;
  } csfu_gp_type;

endpackage : csfu_pkg

// ---- csfu_status_flag_unit.sv ----
// Functional notes
// [RULE1] Flags register read-only, read opcode 0xE2
// [RULE2] Reading flags never changes them
// [RULE3] Flags clear themselves when condition ends
// [RULE4] Bit 7 transmit empty, one after reset
// [RULE5] Bit 6 transmit full, zero after reset
// [RULE6] Bit 5 history FIFO full, eight entries
// [RULE7] Bit 4 either error count 96..127
// [RULE8] Bit 3 error passive, zero after reset
// [RULE9] Bit 2 bus-off, zero after reset
// [RULE10] Bit 1 receive empty, one after reset
// [RULE11] Bit 0 receive full, zero after reset
// [RULE12] Enables written 0x1E, read 0xE6
// [RULE13] Status pin high on any enabled flag
// [RULE14] Enables reset to bits 7 and 1
// [RULE15] Any flag selectable onto general pins
// [RULE16] Selector codes 1000..1111 map the flags
// [RULE17] Flags recomputed every clock from engine
`timescale 1ns/10ps
module csfu_status_flag_unit (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire csfu_pkg::csfu_engine_type engine,
  input  wire csfu_pkg::csfu_access_type access,
  input  wire csfu_pkg::csfu_gp_type     gp_in,
  output logic [7:0]                     rdata_q,
  output logic                           rvalid_q,
  output logic [7:0]                     status_flags_q,
  output logic [7:0]                     status_flag_enables_q,
  output logic                           status_pin_q,
  output logic                           general_pin_one_q,
  output logic                           general_pin_two_q
);
  import csfu_pkg::*;

  logic [7:0] status_flags_d;
  logic       status_pin_d;
  logic [3:0] sel_one;
  logic [3:0] sel_two;

  // Flag conditions from engine state, recomputed each cycle
  always_comb begin
    status_flags_d = 8'h00; // [RULE3] [RULE17]
    status_flags_d[CSFU_BIT_TX_EMPTY]    = (engine.tx_count == 4'h0); // [RULE4]
    status_flags_d[CSFU_BIT_TX_FULL]     = (engine.tx_count >= CSFU_TX_DEPTH); // [RULE5]
    status_flags_d[CSFU_BIT_TX_HISTORY]  = (engine.history_count >= CSFU_HISTORY_DEPTH); // [RULE6]
    status_flags_d[CSFU_BIT_ERR_WARNING] =
      ((engine.tx_error_count >= CSFU_WARN_LOW) && (engine.tx_error_count <= CSFU_WARN_HIGH)) ||
      ((engine.rx_error_count >= CSFU_WARN_LOW) && (engine.rx_error_count <= CSFU_WARN_HIGH)); // [RULE7]
    status_flags_d[CSFU_BIT_ERR_PASSIVE] = (engine.fc_state == CSFU_FC_PASSIVE); // [RULE8]
    status_flags_d[CSFU_BIT_BUS_OFF]     = (engine.fc_state == CSFU_FC_BUS_OFF); // [RULE9]
    status_flags_d[CSFU_BIT_RX_EMPTY]    = (engine.rx_count == 4'h0); // [RULE10]
    status_flags_d[CSFU_BIT_RX_FULL]     = (engine.rx_count >= CSFU_RX_DEPTH); // [RULE11]
  end

  // Flags register, independent of host reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_flags_q <= CSFU_FLAGS_RESET; // [RULE4] [RULE10]
    end else begin
      status_flags_q <= status_flags_d; // [RULE2] [RULE17]
    end
  end

  // Enable register, only written by its own opcode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_flag_enables_q <= CSFU_ENABLE_RESET; // [RULE14]
    end else if (access.write_strobe && access.opcode == CSFU_OP_ENABLE_WRITE) begin
      status_flag_enables_q <= access.wdata; // [RULE12]
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= 1'b0;
      if (access.read_strobe) begin
        rvalid_q <= 1'b1;
        unique case (access.opcode)
          CSFU_OP_FLAGS_READ:  rdata_q <= status_flags_q; // [RULE1]
          CSFU_OP_ENABLE_READ: rdata_q <= status_flag_enables_q; // [RULE12]
          default:             rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Status pin follows the enabled flags
  assign status_pin_d = |(status_flags_d & status_flag_enables_q); // [RULE13]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_pin_q <= 1'b1;
    end else begin
      status_pin_q <= status_pin_d; // [RULE13]
    end
  end

  // General pins: low codes pick interrupt flags, high codes status flags
  assign sel_one = gp_in.gp_pin_select[3:0];
  assign sel_two = gp_in.gp_pin_select[7:4];

  function automatic logic csfu_pick(input logic [3:0] sel, input logic [7:0] stat,
                                     input logic [7:0] intr);
    if (sel >= CSFU_GP_STATUS_BASE) begin
      csfu_pick = stat[sel[2:0]]; // [RULE16]
    end else begin
      csfu_pick = intr[sel[2:0]];
    end
  endfunction : csfu_pick

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      general_pin_one_q <= 1'b0;
      general_pin_two_q <= 1'b0;
    end else begin
      general_pin_one_q <= csfu_pick(sel_one, status_flags_d, gp_in.interrupt_flags); // [RULE15]
      general_pin_two_q <= csfu_pick(sel_two, status_flags_d, gp_in.interrupt_flags); // [RULE15]
    end
  end

  // Checks
  // Values held while reset is applied
  a_reset_tx_empty: assert property ( // [RULE4]
    @(posedge clk)
    reset |=>
      status_flags_q[CSFU_BIT_TX_EMPTY])
    else $error("tx empty not set by reset");

  a_reset_tx_full: assert property ( // [RULE5]
    @(posedge clk)
    reset |=>
      !status_flags_q[CSFU_BIT_TX_FULL])
    else $error("tx full set by reset");

  a_reset_passive: assert property ( // [RULE8]
    @(posedge clk)
    reset |=>
      !status_flags_q[CSFU_BIT_ERR_PASSIVE])
    else $error("error passive set by reset");

  a_reset_bus_off: assert property ( // [RULE9]
    @(posedge clk)
    reset |=>
      !status_flags_q[CSFU_BIT_BUS_OFF])
    else $error("bus-off set by reset");

  a_reset_rx_empty: assert property ( // [RULE10]
    @(posedge clk)
    reset |=>
      status_flags_q[CSFU_BIT_RX_EMPTY])
    else $error("rx empty not set by reset");

  a_reset_rx_full: assert property ( // [RULE11]
    @(posedge clk)
    reset |=>
      !status_flags_q[CSFU_BIT_RX_FULL])
    else $error("rx full set by reset");

  a_reset_enables: assert property ( // [RULE14]
    @(posedge clk)
    reset |=>
      status_flag_enables_q == CSFU_ENABLE_RESET)
    else $error("enables wrong after reset");

  a_reset_pin: assert property ( // [RULE13]
    @(posedge clk)
    reset |=>
      status_pin_q)
    else $error("status pin low during reset");

  // Flags follow the engine one clock later
  a_flags_follow_tx: assert property ( // [RULE4]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_TX_EMPTY] ==
      ($past(engine.tx_count) == 4'h0))
    else $error("tx empty flag wrong");

  a_follow_tx_full: assert property ( // [RULE5]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_TX_FULL] ==
      ($past(engine.tx_count) >= CSFU_TX_DEPTH))
    else $error("tx full flag wrong");

  a_follow_history: assert property ( // [RULE6]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_TX_HISTORY] ==
      ($past(engine.history_count) >= CSFU_HISTORY_DEPTH))
    else $error("history full flag wrong");

  a_follow_passive: assert property ( // [RULE8]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_ERR_PASSIVE] ==
      ($past(engine.fc_state) == CSFU_FC_PASSIVE))
    else $error("error passive flag wrong");

  a_follow_bus_off: assert property ( // [RULE9]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_BUS_OFF] ==
      ($past(engine.fc_state) == CSFU_FC_BUS_OFF))
    else $error("bus-off flag follow wrong");

  a_follow_rx_empty: assert property ( // [RULE10]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_RX_EMPTY] ==
      ($past(engine.rx_count) == 4'h0))
    else $error("rx empty flag wrong");

  a_flags_follow_rx: assert property ( // [RULE11]
    @(posedge clk) disable iff (reset)
    ##1 status_flags_q[CSFU_BIT_RX_FULL] ==
      ($past(engine.rx_count) >= CSFU_RX_DEPTH))
    else $error("rx full flag wrong");

  a_flag_self_clear: assert property ( // [RULE3]
    @(posedge clk) disable iff (reset)
    (engine.tx_count != 4'h0) |=>
      !status_flags_q[CSFU_BIT_TX_EMPTY])
    else $error("tx empty flag did not clear");

  a_full_not_empty: assert property ( // [RULE17]
    @(posedge clk) disable iff (reset)
    ##1 !(status_flags_q[CSFU_BIT_TX_EMPTY] && status_flags_q[CSFU_BIT_TX_FULL]) &&
      !(status_flags_q[CSFU_BIT_RX_EMPTY] && status_flags_q[CSFU_BIT_RX_FULL]))
    else $error("fifo empty and full together");

  // Error warning window on either count
  a_warning_window: assert property ( // [RULE7]
    @(posedge clk) disable iff (reset)
    (engine.tx_error_count == CSFU_WARN_LOW || engine.rx_error_count == CSFU_WARN_HIGH) |=>
      status_flags_q[CSFU_BIT_ERR_WARNING])
    else $error("warning flag missed");

  a_warning_outside: assert property ( // [RULE7]
    @(posedge clk) disable iff (reset)
    (engine.tx_error_count < CSFU_WARN_LOW && engine.rx_error_count < CSFU_WARN_LOW) |=>
      !status_flags_q[CSFU_BIT_ERR_WARNING])
    else $error("warning flag spurious");

  a_warning_upper: assert property ( // [RULE7]
    @(posedge clk) disable iff (reset)
    (engine.tx_error_count > CSFU_WARN_HIGH && engine.rx_error_count > CSFU_WARN_HIGH) |=>
      !status_flags_q[CSFU_BIT_ERR_WARNING])
    else $error("warning flag above window");

  // Host reads and enable writes
  a_read_keeps_flags: assert property ( // [RULE2]
    @(posedge clk) disable iff (reset)
    (access.read_strobe && $stable(engine)) |=>
      $stable(status_flags_q))
    else $error("read changed flags");

  a_flags_read_data: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    (access.read_strobe && access.opcode == CSFU_OP_FLAGS_READ) |=>
      (rvalid_q && rdata_q == $past(status_flags_q)))
    else $error("flags read data wrong");

  a_read_valid_pulse: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    access.read_strobe |=>
      rvalid_q)
    else $error("read answer missing");

  a_no_valid_idle: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    !access.read_strobe |=>
      !rvalid_q)
    else $error("read answer without request");

  a_enable_read_data: assert property ( // [RULE12]
    @(posedge clk) disable iff (reset)
    (access.read_strobe && access.opcode == CSFU_OP_ENABLE_READ) |=>
      (rvalid_q && rdata_q == $past(status_flag_enables_q)))
    else $error("enable read data wrong");

  a_unknown_read_zero: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    (access.read_strobe && access.opcode != CSFU_OP_FLAGS_READ &&
      access.opcode != CSFU_OP_ENABLE_READ) |=> rdata_q == 8'h00)
    else $error("unknown read not zero");

  a_enable_write: assert property ( // [RULE12]
    @(posedge clk) disable iff (reset)
    (access.write_strobe && access.opcode == CSFU_OP_ENABLE_WRITE) |=>
      status_flag_enables_q == $past(access.wdata))
    else $error("enable write lost");

  a_enable_hold: assert property ( // [RULE12]
    @(posedge clk) disable iff (reset)
    !(access.write_strobe && access.opcode == CSFU_OP_ENABLE_WRITE) |=>
      $stable(status_flag_enables_q))
    else $error("enable changed without write");

  // Status pin and fault confinement flags
  a_status_pin: assert property ( // [RULE13]
    @(posedge clk) disable iff (reset)
    ##1 status_pin_q ==
      |($past(status_flags_d) & $past(status_flag_enables_q)))
    else $error("status pin wrong");

  a_bus_off_flag: assert property ( // [RULE9]
    @(posedge clk) disable iff (reset)
    (engine.fc_state == CSFU_FC_BUS_OFF) |=>
      (status_flags_q[CSFU_BIT_BUS_OFF] && !status_flags_q[CSFU_BIT_ERR_PASSIVE]))
    else $error("bus-off flag wrong");

  a_passive_flag_only: assert property ( // [RULE8]
    @(posedge clk) disable iff (reset)
    (engine.fc_state == CSFU_FC_PASSIVE) |=>
      (status_flags_q[CSFU_BIT_ERR_PASSIVE] && !status_flags_q[CSFU_BIT_BUS_OFF]))
    else $error("error passive flag wrong");

  // General pin selection
  a_gp_status_pick: assert property ( // [RULE16]
    @(posedge clk) disable iff (reset)
    (sel_one == 4'hF) |=>
      general_pin_one_q == $past(status_flags_d[CSFU_BIT_TX_EMPTY]))
    else $error("general pin select wrong");

  a_gp_one_rx_empty: assert property ( // [RULE16]
    @(posedge clk) disable iff (reset)
    (sel_one == 4'h9) |=>
      general_pin_one_q == $past(status_flags_d[CSFU_BIT_RX_EMPTY]))
    else $error("general pin one rx empty wrong");

  a_gp_two_pick: assert property ( // [RULE16]
    @(posedge clk) disable iff (reset)
    (sel_two == 4'h8) |=>
      general_pin_two_q == $past(status_flags_d[CSFU_BIT_RX_FULL]))
    else $error("general pin two select wrong");

  a_gp_intr_pick: assert property ( // [RULE15]
    @(posedge clk) disable iff (reset)
    (sel_one == 4'h0) |=>
      general_pin_one_q == $past(gp_in.interrupt_flags[0]))
    else $error("general pin interrupt select wrong");

endmodule : csfu_status_flag_unit

// ---- test_can_status_flag_unit.sv ----
`timescale 1ns/10ps
module test_can_status_flag_unit;
  import csfu_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  csfu_engine_type eng = '{4'h0, 4'h0, 4'h0, 8'h00, 8'h00, CSFU_FC_ACTIVE};
  csfu_gp_type gp = '{8'hA5, 8'h00};
  csfu_access_type acc;
  logic [7:0] rdata, flags, enables, q;
  logic rvalid, pin, gp1, gp2;
  int n_mismatch = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  csfu_status_flag_unit dut (.clk(clk), .reset(reset), .engine(eng), .access(acc),
    .gp_in(gp), .rdata_q(rdata), .rvalid_q(rvalid), .status_flags_q(flags),
    .status_flag_enables_q(enables), .status_pin_q(pin), .general_pin_one_q(gp1),
    .general_pin_two_q(gp2));
  csfu_host_model host (.clk(clk), .rvalid_q(rvalid), .rdata_q(rdata), .access(acc));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [7:0] exp_flags(csfu_engine_type e);
    return {e.tx_count == 0, e.tx_count >= 8, e.history_count >= 8,
            (e.tx_error_count inside {[96:127]}) || (e.rx_error_count inside {[96:127]}),
            e.fc_state == CSFU_FC_PASSIVE, e.fc_state == CSFU_FC_BUS_OFF,
            e.rx_count == 0, e.rx_count >= 8};
  endfunction : exp_flags
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic test_reset();
    check("flags", 8'h82, flags);
    check("enables", 8'h82, enables);
    check("pin", 8'h01, {7'h00, pin});
    $display("test reset done");
  endtask : test_reset
  task automatic test_flags();
    csfu_engine_type t[6] = '{'{4'h0, 4'h0, 4'h0, 8'h5F, 8'h80, CSFU_FC_ACTIVE},
      '{4'h8, 4'h8, 4'h8, 8'h60, 8'h00, CSFU_FC_PASSIVE},
      '{4'h7, 4'h7, 4'h7, 8'h00, 8'h7F, CSFU_FC_ACTIVE},
      '{4'h3, 4'h1, 4'h2, 8'h80, 8'h5F, CSFU_FC_BUS_OFF},
      '{4'h8, 4'h0, 4'h8, 8'hFF, 8'h7F, CSFU_FC_PASSIVE},
      '{4'h1, 4'h8, 4'h0, 8'h00, 8'h00, CSFU_FC_ACTIVE}};
    foreach (t[i]) begin
      eng = t[i];
      settle();
      check("flags", exp_flags(t[i]), flags);
      host.xfer(1'b0, CSFU_OP_FLAGS_READ, 8'h00, q);
      check("flag read", exp_flags(t[i]), q);
      host.xfer(1'b0, CSFU_OP_FLAGS_READ, 8'h00, q);
      check("flag reread", exp_flags(t[i]), q);
    end
    $display("test flags done");
  endtask : test_flags
  task automatic test_enables();
    eng = '{4'h1, 4'h8, 4'h0, 8'h00, 8'h00, CSFU_FC_ACTIVE};
    host.xfer(1'b1, CSFU_OP_ENABLE_WRITE, 8'h01, q);
    settle();
    check("pin on", 8'h01, {7'h00, pin});
    host.xfer(1'b1, CSFU_OP_ENABLE_WRITE, 8'hFE, q);
    host.xfer(1'b1, CSFU_OP_FLAGS_READ, 8'hFF, q);
    settle();
    check("pin off", 8'h00, {7'h00, pin});
    check("flags kept", 8'h01, flags);
    host.xfer(1'b0, CSFU_OP_ENABLE_READ, 8'h00, q);
    check("enable read", 8'hFE, q);
    host.xfer(1'b0, 8'h22, 8'h00, q);
    check("unknown read", 8'h00, q);
    $display("test enables done");
  endtask : test_enables
  task automatic test_gp_pins();
    logic [15:0] src;
    src = {exp_flags(eng), gp.interrupt_flags};
    for (int c = 0; c < 16; c++) begin
      gp.gp_pin_select = {4'(15 - c), 4'(c)};
      settle();
      check("gp one", {7'h00, src[c]}, {7'h00, gp1});
      check("gp two", {7'h00, src[15 - c]}, {7'h00, gp2});
    end
    $display("test gp pins done");
  endtask : test_gp_pins
  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset();
    test_flags();
    test_enables();
    test_gp_pins();
    stop_test();
  end
endmodule : test_can_status_flag_unit
